// ==== src/tx_seq_pkg.sv ====
package tx_seq_pkg;
  // Short register offsets
  localparam logic [8:0] ADDR_ACK_TIMEOUT = 9'h012;
  localparam logic [8:0] ADDR_BEACON_CTL = 9'h01a;
  localparam logic [8:0] ADDR_NORMAL_CTL = 9'h01b;
  localparam logic [8:0] ADDR_SLOT1_CTL = 9'h01c;
  localparam logic [8:0] ADDR_SLOT2_CTL = 9'h01d;
  localparam logic [8:0] ADDR_TX_STATUS = 9'h024;
  localparam logic [8:0] ADDR_IRQ_FLAGS = 9'h031;
  localparam logic [8:0] ADDR_IRQ_EN = 9'h032;
  // Control field positions
  localparam int BIT_TRIG = 0;
  localparam int BIT_SECURE = 1;
  localparam int BIT_ACKREQ = 2;
  localparam int BIT_INDIRECT = 3;
  localparam int SLOT_LSB = 3;
  localparam int RETRY_LSB = 6;
  // Status field positions
  localparam int ST_NORMAL = 0;
  localparam int ST_SLOT1 = 1;
  localparam int ST_NOTIME1 = 3;
  localparam int ST_BUSY = 5;
  localparam int ST_NRETRY = 6;
  // Fifo memory layout
  localparam logic [8:0] BASE_NORMAL = 9'h000;
  localparam logic [8:0] BASE_BEACON = 9'h080;
  localparam logic [8:0] BASE_SLOT1 = 9'h100;
  localparam logic [8:0] BASE_SLOT2 = 9'h180;
  localparam logic [8:0] FLEN_OFS = 9'h001;
  localparam logic [8:0] HDR_OFS = 9'h002;
  localparam int HDR_LEN_W = 5;
  // Reset values and timing
  localparam logic [6:0] ACK_WAIT_RESET = 7'h36;
  localparam logic [1:0] MAX_RETRIES = 2'h3;
  localparam int TURNAROUND_SYM = 12;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYMBOL_NS = 16000;
  localparam int SYMBOL_CYC = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // On-air framing
  localparam logic [7:0] PREAMBLE_LEN = 8'h04;
  localparam logic [7:0] SHR_PHR_LEN = 8'h06;
  localparam logic [7:0] SFD_BYTE = 8'ha7;
  localparam logic [6:0] FCS_LEN = 7'h02;
  localparam logic [15:0] FCS_POLY = 16'h8408;
  localparam logic [7:0] ACK_FC0 = 8'h02;
  localparam logic [7:0] ACK_FC1 = 8'h00;
  localparam logic [6:0] ACK_MPDU_LEN = 7'h03;

  typedef enum logic [2:0] {
    SRC_NORMAL = 3'h0,
    SRC_BEACON = 3'h1,
    SRC_SLOT1 = 3'h2,
    SRC_SLOT2 = 3'h3,
    SRC_ACK = 3'h4
  } src_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_CSMA = 6'h02,
    S_SEND = 6'h04,
    S_ACKWAIT = 6'h08,
    S_DONE = 6'h10,
    S_FLAG = 6'h20
  } state_t;

  typedef struct packed {
    logic long_space;
    logic [8:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic beacon_mode;
    logic beacon_slot_start;
    logic cfp_active;
    logic slot_start;
    logic [2:0] current_slot;
    logic slot_time_short;
  } superframe_t;
endpackage

// ==== src/tx_fifo_sequencer_ack_retry.sv ====
`timescale 1ns/10ps
`default_nettype none
module tx_fifo_sequencer_ack_retry (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire tx_seq_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire tx_seq_pkg::superframe_t sframe,
  output logic csma_req,
  input wire logic csma_done,
  input wire logic csma_busy,
  input wire logic ack_rx,
  input wire logic ack_send,
  input wire logic [7:0] ack_seq,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_secure,
  output logic [4:0] tx_sec_hdr_len
);
  import tx_seq_pkg::*;

  logic [7:0] fifo_mem [0:511];
  logic [1:0] beacon_tx_control;
  logic [3:0] normal_tx_control;
  logic [7:0] slot_tx_control [0:1];
  logic [7:0] tx_result_status;
  logic [2:0] irq_flags;
  logic [7:0] irq_enables;
  logic [6:0] ack_wait_duration;
  state_t state;
  src_t src;
  src_t next_src;
  logic start;
  logic [8:0] base;
  logic [7:0] idx;
  logic [6:0] flen;
  logic [1:0] retry;
  logic [6:0] sym_cnt;
  logic [7:0] sym_div;
  logic sym_tick;
  logic res_fail;
  logic res_busy;
  logic res_notime;
  logic ack_pend;
  logic [7:0] ack_seq_q;
  logic [15:0] crc;
  logic [7:0] gen_byte;
  logic push;
  logic last_byte;
  logic in_frame;
  logic [7:0] buf0;
  logic [7:0] buf1;
  logic [1:0] buf_cnt;
  logic buf_in_ready;
  logic pop;
  logic needs_ack;
  logic direct;
  logic timeout;
  logic go_slot [0:1];
  logic wr_short;

  assign wr_short = reg_req.wr && !reg_req.long_space;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ FCS_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Fifo memory: host writes the long space
  always_ff @(posedge ref_clk)
  begin
    if (reg_req.wr && reg_req.long_space)
      fifo_mem[reg_req.addr] <= reg_req.wdata;
  end

  // Symbol tick from the reference clock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || sym_tick)
      sym_div <= 8'h00;
    else
      sym_div <= sym_div + 8'h01;
  end
  assign sym_tick = (sym_div == 8'(SYMBOL_CYC - 1));

  // Beacon and normal control; a host write in the start cycle re-arms
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      beacon_tx_control <= 2'h0;
      normal_tx_control <= 4'h0;
    end
    else
    begin
      if (start && next_src == SRC_BEACON)
        beacon_tx_control[BIT_TRIG] <= 1'b0;
      if (start && next_src == SRC_NORMAL)
        normal_tx_control[BIT_TRIG] <= 1'b0;
      if (wr_short && reg_req.addr == ADDR_BEACON_CTL)
        beacon_tx_control <= reg_req.wdata[1:0];
      if (wr_short && reg_req.addr == ADDR_NORMAL_CTL)
        normal_tx_control <= reg_req.wdata[3:0];
    end
  end

  // Per-slot control, trigger gating and retry report
  for (genvar g = 0; g < 2; g++)
  begin : g_slot
    localparam logic [8:0] CTL_ADDR = g ? ADDR_SLOT2_CTL : ADDR_SLOT1_CTL;
    localparam src_t MY_SRC = g ? SRC_SLOT2 : SRC_SLOT1;
    assign go_slot[g] = slot_tx_control[g][BIT_TRIG] && sframe.beacon_mode
      && sframe.cfp_active && sframe.slot_start
      && sframe.current_slot == slot_tx_control[g][SLOT_LSB +: 3];
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        slot_tx_control[g] <= 8'h00;
      else
      begin
        if (start && next_src == MY_SRC)
          slot_tx_control[g][BIT_TRIG] <= 1'b0;
        if (state == S_DONE && src == MY_SRC)
          slot_tx_control[g][RETRY_LSB +: 2] <= retry;
        if (wr_short && reg_req.addr == CTL_ADDR)
          slot_tx_control[g] <= reg_req.wdata;
      end
    end
  end

  // Remaining host registers and the pending ack request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irq_enables <= 8'h00;
      ack_wait_duration <= ACK_WAIT_RESET;
      ack_pend <= 1'b0;
      ack_seq_q <= 8'h00;
    end
    else
    begin
      if (wr_short && reg_req.addr == ADDR_IRQ_EN)
        irq_enables <= reg_req.wdata;
      if (wr_short && reg_req.addr == ADDR_ACK_TIMEOUT)
        ack_wait_duration <= reg_req.wdata[6:0];
      // New request wins over the clear of the one being served
      if (ack_send)
      begin
        ack_pend <= 1'b1;
        ack_seq_q <= ack_seq;
      end
      else if (start && next_src == SRC_ACK)
        ack_pend <= 1'b0;
    end
  end

  // Source selection; acks first since they must meet the turnaround
  always_comb
  begin
    next_src = SRC_NORMAL;
    start = 1'b0;
    if (state == S_IDLE)
    begin
      start = 1'b1;
      if (ack_pend)
        next_src = SRC_ACK;
      else if (beacon_tx_control[BIT_TRIG]
               && (!sframe.beacon_mode || sframe.beacon_slot_start))
        next_src = SRC_BEACON;
      else if (go_slot[0])
        next_src = SRC_SLOT1;
      else if (go_slot[1])
        next_src = SRC_SLOT2;
      else if (normal_tx_control[BIT_TRIG] && !(sframe.beacon_mode && sframe.cfp_active))
        next_src = SRC_NORMAL;
      else
        start = 1'b0;
    end
  end

  // Fifo base and per-source options
  always_comb
  begin
    case (src)
      SRC_BEACON: base = BASE_BEACON;
      SRC_SLOT1: base = BASE_SLOT1;
      SRC_SLOT2: base = BASE_SLOT2;
      default: base = BASE_NORMAL;
    endcase
    case (src)
      SRC_NORMAL: needs_ack = normal_tx_control[BIT_ACKREQ];
      SRC_SLOT1: needs_ack = slot_tx_control[0][BIT_ACKREQ];
      SRC_SLOT2: needs_ack = slot_tx_control[1][BIT_ACKREQ];
      default: needs_ack = 1'b0;
    endcase
  end
  assign direct = !(src == SRC_NORMAL && normal_tx_control[BIT_INDIRECT]);
  // Fires on the tick that ends the last allowed symbol, never one late
  assign timeout = sym_tick && buf_cnt == 2'h0
    && ({1'b0, sym_cnt} + 8'h01 >= {1'b0, ack_wait_duration});

  // Byte generator: preamble, SFD, PHY length, MPDU, FCS
  always_comb
  begin
    in_frame = 1'b0;
    if (idx < PREAMBLE_LEN)
      gen_byte = 8'h00;
    else if (idx == PREAMBLE_LEN)
      gen_byte = SFD_BYTE;
    else if (idx == PREAMBLE_LEN + 8'h01)
      gen_byte = {1'b0, flen + FCS_LEN};
    else if (idx < SHR_PHR_LEN + {1'b0, flen})
    begin
      in_frame = 1'b1;
      if (src != SRC_ACK)
        gen_byte = fifo_mem[base + HDR_OFS + {1'b0, idx} - {1'b0, SHR_PHR_LEN}];
      else if (idx == SHR_PHR_LEN)
        gen_byte = ACK_FC0;
      else if (idx == SHR_PHR_LEN + 8'h01)
        gen_byte = ACK_FC1;
      else
        gen_byte = ack_seq_q;
    end
    else if (idx == SHR_PHR_LEN + {1'b0, flen})
      gen_byte = crc[7:0];
    else
      gen_byte = crc[15:8];
  end
  assign push = state == S_SEND && buf_in_ready;
  assign last_byte = idx == SHR_PHR_LEN + {1'b0, flen} + 8'h01;

  // FCS over the MPDU only; cleared outside SEND so a retry starts afresh
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || state != S_SEND)
      crc <= 16'h0000;
    else if (push && in_frame)
      crc <= crc_byte(crc, gen_byte);
  end

  // Sequencer: CSMA, send, ack wait, retries, completion
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      src <= SRC_NORMAL;
      idx <= 8'h00;
      flen <= 7'h00;
      retry <= 2'h0;
      sym_cnt <= 7'h00;
      res_fail <= 1'b0;
      res_busy <= 1'b0;
      res_notime <= 1'b0;
      tx_secure <= 1'b0;
      tx_sec_hdr_len <= 5'h00;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            src <= next_src;
            idx <= 8'h00;
            retry <= 2'h0;
            res_fail <= 1'b0;
            res_busy <= 1'b0;
            res_notime <= 1'b0;
            tx_secure <= 1'b0;
            tx_sec_hdr_len <= 5'h00;
            if (next_src == SRC_ACK)
            begin
              flen <= ACK_MPDU_LEN;
              state <= S_SEND;
            end
            else
            begin
              flen <= fifo_mem[base_of(next_src) + FLEN_OFS][6:0];
              if (sec_of(next_src))
              begin
                tx_secure <= 1'b1;
                tx_sec_hdr_len <= fifo_mem[base_of(next_src)][HDR_LEN_W-1:0];
              end
              if ((next_src == SRC_SLOT1 || next_src == SRC_SLOT2) && sframe.slot_time_short)
              begin
                res_fail <= 1'b1;
                res_notime <= 1'b1;
                state <= S_DONE;
              end
              else if (next_src == SRC_NORMAL)
                state <= S_CSMA;
              else
                state <= S_SEND;
            end
          end
        end
        S_CSMA:
        begin
          if (csma_done && csma_busy)
          begin
            res_fail <= 1'b1;
            res_busy <= 1'b1;
            state <= S_DONE;
          end
          else if (csma_done)
          begin
            idx <= 8'h00;
            state <= S_SEND;
          end
        end
        S_SEND:
        begin
          if (push)
          begin
            idx <= idx + 8'h01;
            if (last_byte)
            begin
              sym_cnt <= 7'h00;
              state <= needs_ack ? S_ACKWAIT : S_DONE;
            end
          end
        end
        S_ACKWAIT:
        begin
          if (sym_tick && buf_cnt == 2'h0)
            sym_cnt <= sym_cnt + 7'h01;
          if (ack_rx && buf_cnt == 2'h0)
            state <= S_DONE;
          else if (timeout && retry < MAX_RETRIES && direct)
          begin
            retry <= retry + 2'h1;
            idx <= 8'h00;
            state <= (src == SRC_NORMAL) ? S_CSMA : S_SEND;
          end
          else if (timeout)
          begin
            res_fail <= 1'b1;
            state <= S_DONE;
          end
        end
        S_DONE: state <= (src == SRC_ACK || src == SRC_BEACON) ? S_IDLE : S_FLAG;
        S_FLAG: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  function automatic logic [8:0] base_of(input src_t s);
    case (s)
      SRC_BEACON: return BASE_BEACON;
      SRC_SLOT1: return BASE_SLOT1;
      SRC_SLOT2: return BASE_SLOT2;
      default: return BASE_NORMAL;
    endcase
  endfunction

  function automatic logic sec_of(input src_t s);
    case (s)
      SRC_BEACON: return beacon_tx_control[BIT_SECURE];
      SRC_SLOT1: return slot_tx_control[0][BIT_SECURE];
      SRC_SLOT2: return slot_tx_control[1][BIT_SECURE];
      default: return normal_tx_control[BIT_SECURE];
    endcase
  endfunction

  assign csma_req = state == S_CSMA;

  // Status is written in S_DONE, one cycle before the flag in S_FLAG
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tx_result_status <= 8'h00;
    else if (state == S_DONE && src == SRC_NORMAL)
    begin
      tx_result_status[ST_NORMAL] <= res_fail;
      tx_result_status[ST_BUSY] <= res_busy;
      tx_result_status[ST_NRETRY +: 2] <= retry;
    end
    else if (state == S_DONE && (src == SRC_SLOT1 || src == SRC_SLOT2))
    begin
      tx_result_status[ST_SLOT1 + int'(src == SRC_SLOT2)] <= res_fail;
      tx_result_status[ST_NOTIME1 + int'(src == SRC_SLOT2)] <= res_notime;
      tx_result_status[ST_BUSY] <= 1'b0;
    end
  end

  // Completion flags clear on read; a set in that cycle wins
  always_ff @(posedge ref_clk)
  begin
    logic [2:0] set;
    logic [2:0] clr;
    set = 3'h0;
    clr = 3'h0;
    if (state == S_FLAG)
      set[src[1:0] == 2'h0 ? 0 : src[1:0] - 2'h1] = 1'b1;
    if (reg_req.rd && !reg_req.long_space && reg_req.addr == ADDR_IRQ_FLAGS)
      clr = 3'h7;
    if (!rst_n)
      irq_flags <= 3'h0;
    else
      irq_flags <= (irq_flags & ~clr) | set;
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_req.rd && reg_req.long_space)
      reg_rdata <= fifo_mem[reg_req.addr];
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        ADDR_ACK_TIMEOUT: reg_rdata <= {1'b0, ack_wait_duration};
        ADDR_BEACON_CTL: reg_rdata <= {6'h00, beacon_tx_control};
        ADDR_NORMAL_CTL: reg_rdata <= {4'h0, normal_tx_control};
        ADDR_SLOT1_CTL: reg_rdata <= slot_tx_control[0];
        ADDR_SLOT2_CTL: reg_rdata <= slot_tx_control[1];
        ADDR_TX_STATUS: reg_rdata <= tx_result_status;
        ADDR_IRQ_FLAGS: reg_rdata <= {5'h00, irq_flags};
        ADDR_IRQ_EN: reg_rdata <= irq_enables;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Two-entry buffer toward the radio; a stall holds the generator
  assign buf_in_ready = buf_cnt != 2'h2;
  assign pop = tx_valid && tx_ready;
  assign tx_valid = buf_cnt != 2'h0;
  assign tx_data = buf0;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      buf_cnt <= 2'h0;
      buf0 <= 8'h00;
      buf1 <= 8'h00;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (buf_cnt == 2'h0)
            buf0 <= gen_byte;
          else
            buf1 <= gen_byte;
          buf_cnt <= buf_cnt + 2'h1;
        end
        2'b01:
        begin
          buf0 <= buf1;
          buf_cnt <= buf_cnt - 2'h1;
        end
        2'b11:
        begin
          if (buf_cnt == 2'h1)
            buf0 <= gen_byte;
          else
          begin
            buf0 <= buf1;
            buf1 <= gen_byte;
          end
        end
        default: buf_cnt <= buf_cnt;
      endcase
    end
  end

  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_beacon_timing: assert property (
    start && next_src == SRC_BEACON |-> !sframe.beacon_mode || sframe.beacon_slot_start)
    else $error("beacon started outside its slot");
  chk_beacon_trig_clear: assert property (
    start && next_src == SRC_BEACON && !(wr_short && reg_req.addr == ADDR_BEACON_CTL)
    |=> !beacon_tx_control[BIT_TRIG])
    else $error("beacon trigger not cleared");
  chk_slot_window: assert property (
    start && next_src == SRC_SLOT1 |-> sframe.cfp_active
    && sframe.current_slot == slot_tx_control[0][SLOT_LSB +: 3])
    else $error("slot fifo sent outside its slot");
  chk_slot_trig_clear: assert property (
    start && next_src == SRC_SLOT2 && !(wr_short && reg_req.addr == ADDR_SLOT2_CTL)
    |=> !slot_tx_control[1][BIT_TRIG])
    else $error("slot trigger not cleared");
  chk_flag_after_status: assert property (
    state == S_FLAG && src == SRC_SLOT1
    |-> tx_result_status[ST_SLOT1] == res_fail ##1 irq_flags[1])
    else $error("flag raised before status settled");
  chk_ack_wait_bound: assert property (
    state == S_ACKWAIT |-> sym_cnt <= ack_wait_duration)
    else $error("ack wait overran its duration");
  chk_retry_limit: assert property (
    state == S_ACKWAIT && timeout && !ack_rx && retry == MAX_RETRIES
    |=> state == S_DONE && res_fail)
    else $error("retry beyond the limit");
  chk_indirect_no_retry: assert property (
    state == S_ACKWAIT && timeout && !direct |=> state == S_DONE)
    else $error("indirect frame retransmitted");
  chk_ack_no_csma: assert property (
    ack_send && state == S_IDLE && !start
    |=> ##1 state == S_SEND && src == SRC_ACK && !csma_req)
    else $error("ack frame delayed or used CSMA");
  chk_sfd_position: assert property (
    push && idx <= PREAMBLE_LEN
    |-> gen_byte == ((idx == PREAMBLE_LEN) ? SFD_BYTE : 8'h00))
    else $error("sync header malformed");
  chk_hdr_len_secure: assert property (
    !tx_secure |-> tx_sec_hdr_len == 5'h00)
    else $error("header length used without security");

  cov_ack_retry: cover property (state == S_ACKWAIT && timeout && retry == 2'h1);
  cov_slot_done: cover property (state == S_FLAG && src == SRC_SLOT2);
  cov_busy_fail: cover property (state == S_CSMA && csma_done && csma_busy);
  cov_stall_full: cover property (buf_cnt == 2'h2 && !tx_ready);
endmodule
`default_nettype wire

// ==== tb/radio_far_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module radio_far_end (
  input wire logic ref_clk,
  input wire logic tx_valid,
  input wire logic csma_req,
  input wire logic ack_give,
  input wire logic busy_give,
  output logic tx_ready,
  output logic csma_done,
  output logic csma_busy,
  output logic ack_rx
);
  integer seed = 51;
  int idle = 0;
  // Channel reads busy only while the bench asks for it
  assign csma_busy = busy_give;
  initial
  begin
    tx_ready = 1'b0;
    csma_done = 1'b0;
    ack_rx = 1'b0;
  end
  // Random stalls push the two-entry buffer; ack 30 cycles after the frame
  always @(posedge ref_clk)
  begin
    tx_ready <= ($random(seed) % 4) != 0;
    csma_done <= csma_req && !csma_done;
    idle <= tx_valid ? 1 : (idle == 0 ? 0 : idle + 1);
    ack_rx <= ack_give && idle == 30;
  end
endmodule
`default_nettype wire

// ==== tb/tx_fifo_sequencer_ack_retry_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module tx_fifo_sequencer_ack_retry_bench;
  import tx_seq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t reg_req = '0;
  superframe_t sframe = '0;
  logic ack_send = 1'b0;
  logic [7:0] ack_seq = 8'h00;
  logic ack_give = 1'b0;
  logic busy_give = 1'b0;
  logic [7:0] reg_rdata, tx_data;
  logic [4:0] tx_sec_hdr_len;
  logic csma_req, csma_done, csma_busy, ack_rx, tx_valid, tx_ready, tx_secure;
  logic rd_pend = 1'b0;
  logic [7:0] eq[$], rq[$], mq[$];
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  integer seed = 51;

  always #50 ref_clk = ~ref_clk;

  tx_fifo_sequencer_ack_retry tx_fifo_sequencer_ack_retry_i (.ref_clk, .rst_n,
    .reg_req, .reg_rdata, .sframe, .csma_req, .csma_done, .csma_busy, .ack_rx,
    .ack_send, .ack_seq, .tx_data, .tx_valid, .tx_ready, .tx_secure,
    .tx_sec_hdr_len);
  radio_far_end radio_far_end_i (.ref_clk, .tx_valid, .csma_req, .ack_give, .busy_give,
    .tx_ready, .csma_done, .csma_busy, .ack_rx);

  task automatic tally(input logic [7:0] got, input logic [7:0] exp);
  begin
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    tally(got, exp);
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tally(got, exp);
  endtask
  task automatic cmp_sec(input logic [7:0] got, input logic [7:0] exp);
    tally(got, exp);
  endtask

  task automatic final_report();
  begin
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // Read data lands the cycle after the strobe; any unexpected byte fails
  always @(posedge ref_clk)
  begin
    cycles++;
    if (rd_pend)
      cmp_reg(reg_rdata, rq.pop_front());
    rd_pend <= reg_req.rd;
    if (tx_valid && tx_ready)
      cmp_byte(tx_data, eq.size() ? eq.pop_front() : 8'hxx);
    if (cycles > 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic wr(input logic ls, input logic [8:0] a, input logic [7:0] d);
  begin
    @(posedge ref_clk);
    reg_req <= '{ls, a, 1'b1, 1'b0, d};
    @(posedge ref_clk);
    reg_req <= '0;
  end
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
  begin
    rq.push_back(exp);
    @(posedge ref_clk);
    reg_req <= '{1'b0, a, 1'b0, 1'b1, 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
  end
  endtask

  // Fills a fifo with random MPDU bytes kept in mq
  task automatic load(input logic [8:0] base, input int n);
  begin
    mq.delete();
    wr(1'b1, base, 8'(n));
    wr(1'b1, base + FLEN_OFS, 8'(n));
    for (int i = 0; i < n; i++)
    begin
      mq.push_back(8'($random(seed)));
      wr(1'b1, base + HDR_OFS + 9'(i), mq[i]);
    end
  end
  endtask

  // Preamble, sync, length, MPDU, then reflected CRC low byte first
  task automatic expect_frame();
    logic [15:0] c;
  begin
    c = 16'h0000;
    repeat (PREAMBLE_LEN) eq.push_back(8'h00);
    eq.push_back(SFD_BYTE);
    eq.push_back(8'(mq.size()) + 8'h02);
    foreach (mq[i])
    begin
      eq.push_back(mq[i]);
      for (int k = 0; k < 8; k++)
        c = (c[0] ^ mq[i][k]) ? (c >> 1) ^ FCS_POLY : c >> 1;
    end
    eq.push_back(c[7:0]);
    eq.push_back(c[15:8]);
  end
  endtask

  task automatic drain(input int extra);
  begin
    for (int i = 0; i < 3000 && eq.size() > 0; i++)
      @(posedge ref_clk);
    repeat (extra) @(posedge ref_clk);
  end
  endtask

  initial
  begin
    logic [7:0] v;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_ACK_TIMEOUT, 8'(ACK_WAIT_RESET));
    rd(9'h005, 8'h00);
    wr(1'b0, ADDR_IRQ_EN, 8'ha5);
    rd(ADDR_IRQ_EN, 8'ha5);
    // Beacon goes out at once outside beacon mode
    load(BASE_BEACON, 5);
    expect_frame();
    wr(1'b0, ADDR_BEACON_CTL, 8'h01);
    rd(ADDR_BEACON_CTL, 8'h00);
    drain(5);
    // Ack frame with a random sequence number, no CSMA
    v = 8'($random(seed));
    mq = {ACK_FC0, ACK_FC1, v};
    expect_frame();
    @(posedge ref_clk);
    ack_send <= 1'b1;
    ack_seq <= v;
    @(posedge ref_clk);
    ack_send <= 1'b0;
    drain(5);
    // Slot 1 ignores the wrong slot, then sends and gets its ack
    load(BASE_SLOT1, 6);
    wr(1'b0, ADDR_SLOT1_CTL, 8'h2d);
    ack_give <= 1'b1;
    sframe <= '{1'b1, 1'b0, 1'b1, 1'b1, 3'h4, 1'b0};
    @(posedge ref_clk);
    sframe.slot_start <= 1'b0;
    repeat (20) @(posedge ref_clk);
    expect_frame();
    sframe <= '{1'b1, 1'b0, 1'b1, 1'b1, 3'h5, 1'b0};
    @(posedge ref_clk);
    sframe.slot_start <= 1'b0;
    drain(400);
    rd(ADDR_SLOT1_CTL, 8'h2c);
    rd(ADDR_TX_STATUS, 8'h00);
    rd(ADDR_IRQ_FLAGS, 8'h02);
    // Normal fifo, no ack ever arrives: three retries, then failure
    sframe <= '0;
    ack_give <= 1'b0;
    wr(1'b0, ADDR_ACK_TIMEOUT, 8'h02);
    load(BASE_NORMAL, 4);
    repeat (4) expect_frame();
    wr(1'b0, ADDR_NORMAL_CTL, 8'h05);
    drain(400);
    rd(ADDR_TX_STATUS, 8'hc1);
    rd(ADDR_IRQ_FLAGS, 8'h01);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_NORMAL_CTL, 8'h04);
    // Indirect frame waits for its ack but is never sent again
    expect_frame();
    wr(1'b0, ADDR_NORMAL_CTL, 8'h0d);
    drain(400);
    rd(ADDR_TX_STATUS, 8'h01);
    rd(ADDR_IRQ_FLAGS, 8'h01);
    // Busy channel ends the normal fifo without sending
    busy_give <= 1'b1;
    wr(1'b0, ADDR_NORMAL_CTL, 8'h01);
    repeat (10) @(posedge ref_clk);
    busy_give <= 1'b0;
    rd(ADDR_TX_STATUS, 8'h21);
    rd(ADDR_IRQ_FLAGS, 8'h01);
    // Secure slot 2 with too little slot time left: nothing sent
    load(BASE_SLOT2, 6);
    mq[0][3] = 1'b1;
    wr(1'b1, BASE_SLOT2 + HDR_OFS, mq[0]);
    wr(1'b0, ADDR_SLOT2_CTL, 8'h0b);
    sframe <= '{1'b1, 1'b0, 1'b1, 1'b1, 3'h1, 1'b1};
    @(posedge ref_clk);
    sframe.slot_start <= 1'b0;
    repeat (5) @(posedge ref_clk);
    sframe <= '0;
    rd(ADDR_TX_STATUS, 8'h15);
    rd(ADDR_IRQ_FLAGS, 8'h04);
    rd(ADDR_SLOT2_CTL, 8'h0a);
    cmp_sec(8'({tx_secure, tx_sec_hdr_len}), 8'h26);
    // Secure beacon in beacon mode holds until the beacon slot
    load(BASE_BEACON, 3);
    mq[0][3] = 1'b1;
    wr(1'b1, BASE_BEACON + HDR_OFS, mq[0]);
    sframe <= '{1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0};
    wr(1'b0, ADDR_BEACON_CTL, 8'h03);
    repeat (10) @(posedge ref_clk);
    rd(ADDR_BEACON_CTL, 8'h03);
    expect_frame();
    sframe.beacon_slot_start <= 1'b1;
    @(posedge ref_clk);
    sframe.beacon_slot_start <= 1'b0;
    drain(5);
    cmp_sec(8'({tx_secure, tx_sec_hdr_len}), 8'h23);
    cmp_reg(8'(eq.size()), 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
